// File: hw/icfg_pkg.sv
// package: offsets, field layouts, reset values and code tables of the ir config bank
package icfg_pkg;
  // register offsets (byte address = offset * 4 on wishbone)
  localparam logic [2:0] OFF_RX_DEMOD = 3'h0;
  localparam logic [2:0] OFF_TX_MOD = 3'h1;
  localparam logic [2:0] OFF_REMOTE_CFG = 3'h2;
  localparam logic [2:0] OFF_LINK_BANK = 3'h3;
  localparam logic [2:0] OFF_XCVR_CFG1 = 3'h4;
  localparam logic [2:0] OFF_RSVD_05 = 3'h5;
  localparam logic [2:0] OFF_XCVR_CFG3 = 3'h6;
  localparam logic [2:0] OFF_XCVR_CFG4 = 3'h7;
  // bank numbers
  localparam logic [2:0] BANK_PHY = 3'h6;
  localparam logic [2:0] BANK_REMOTE = 3'h7;
  // reset values
  localparam logic [7:0] RST_RX_DEMOD = 8'h29;
  localparam logic [7:0] RST_TX_MOD = 8'h69;
  localparam logic [7:0] RST_REMOTE_CFG = 8'h00;
  localparam logic [7:0] RST_LINK = 8'h00;
  localparam logic [7:0] RST_XCVR = 8'h00;
  // field positions
  localparam int FREQ_LSB = 0;
  localparam int FREQ_MSB = 4;
  localparam int BW_LSB = 5;
  localparam int BW_MSB = 7;
  localparam int RC_TX_HIGH_BIT = 2;
  localparam int RC_RSVD_BIT = 3;
  localparam int RC_DEMOD_DIS_BIT = 4;
  localparam int RC_RX_HIGH_BIT = 5;
  localparam int XC1_MODE_LSB = 0;
  localparam int XC1_MODE_MSB = 2;
  localparam int XC4_SEL_OUT_BIT = 0;
  localparam int XC4_AUTO_CFG_BIT = 1;
  localparam int XC4_UART_BIT = 2;
  // link control byte: bit 7 set switches to bank select, low 3 bits name the bank
  localparam int LINK_BANK_FLAG_BIT = 7;
  // code tables
  localparam logic [4:0] LOW_CODE_MIN = 5'h03;
  localparam logic [4:0] LOW_CODE_MAX = 5'h1e;
  localparam logic [4:0] HIGH_CODE_400 = 5'h03;
  localparam logic [4:0] HIGH_CODE_450 = 5'h08;
  localparam logic [4:0] HIGH_CODE_480 = 5'h0b;
  localparam logic [2:0] BW_CODE_MIN = 3'h1;
  localparam logic [2:0] BW_CODE_MAX = 3'h6;
  localparam logic [2:0] TX_PW_LOW_MIN = 3'h2;
  localparam logic [2:0] TX_PW_LOW_MAX = 3'h5;
  localparam logic [2:0] TX_PW_HIGH_MIN = 3'h2;
  localparam logic [2:0] TX_PW_HIGH_MAX = 3'h4;
  localparam logic [7:0] RSVD_READ = 8'h00;
endpackage

// File: hw/icfg_code_check.sv
// checks a frequency code for validity in the low or high carrier range
`timescale 1ns/100ps
module icfg_code_check
(
  input wire logic [4:0] freq_code_i,
  input wire logic high_range_i,
  output logic valid_o
);
  // low range 30..56.9 khz, high range has three codes only
  always_comb
  begin
    if (high_range_i)
      valid_o = (freq_code_i == icfg_pkg::HIGH_CODE_400) ||
        (freq_code_i == icfg_pkg::HIGH_CODE_450) ||
        (freq_code_i == icfg_pkg::HIGH_CODE_480);
    else
      valid_o = (freq_code_i >= icfg_pkg::LOW_CODE_MIN) && (freq_code_i <= icfg_pkg::LOW_CODE_MAX);
  end
endmodule // icfg_code_check

// File: hw/icfg_range_check.sv
// checks bandwidth and pulse width codes against their defined spans
`timescale 1ns/100ps
module icfg_range_check
(
  input wire logic [2:0] bw_code_i,
  input wire logic [2:0] pw_code_i,
  input wire logic high_range_i,
  output logic bw_valid_o,
  output logic pw_valid_o
);
  // bandwidth codes 001..110, pulse widths differ per range
  always_comb
  begin
    bw_valid_o = (bw_code_i >= icfg_pkg::BW_CODE_MIN) && (bw_code_i <= icfg_pkg::BW_CODE_MAX);
    if (high_range_i)
      pw_valid_o = (pw_code_i >= icfg_pkg::TX_PW_HIGH_MIN) && (pw_code_i <= icfg_pkg::TX_PW_HIGH_MAX);
    else
      pw_valid_o = (pw_code_i >= icfg_pkg::TX_PW_LOW_MIN) && (pw_code_i <= icfg_pkg::TX_PW_LOW_MAX);
  end
endmodule // icfg_range_check

// File: hw/icfg_bank.sv
// infrared carrier configuration bank: banks 6 and 7 behind a classic wishbone slave
`timescale 1ns/100ps
module icfg_bank
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // active bank as seen by the serial port core
  input wire logic [2:0] bank_i,
  // ask-ir mode is active (else consumer remote)
  input wire logic ask_mode_i,
  // demodulator settings to the receiver
  output logic [4:0] rx_center_freq_o,
  output logic [2:0] rx_bandwidth_o,
  output logic rx_high_range_o,
  output logic rx_demod_enable_o,
  output logic rx_cfg_valid_o,
  // modulator settings to the transmitter
  output logic [4:0] tx_carrier_freq_o,
  output logic [2:0] tx_pulse_width_o,
  output logic tx_high_range_o,
  output logic tx_fixed_500k_o,
  output logic tx_cfg_valid_o,
  // transceiver mode select pins
  output logic [2:0] mode_sel_o,
  output logic [2:0] mode_sel_oe_o,
  // shared link control register
  output logic [7:0] link_control_o
);
  logic [7:0] rx_demod_control;
  logic [7:0] tx_mod_control;
  logic [7:0] remote_ctl_config;
  logic [7:0] link_control;
  logic [7:0] transceiver_config_1;
  logic [7:0] transceiver_config_3;
  logic [7:0] transceiver_config_4;
  logic [2:0] off;
  logic wr_stb;
  logic in_bank7;
  logic [7:0] next_rd;
  logic rx_freq_ok;
  logic tx_freq_ok;
  logic bw_ok;
  logic pw_ok;
  logic next_auto_low;
  // per-register write strobes, decoded once from bank, offset and byte lane
  logic wr_rx_demod;
  logic wr_tx_mod;
  logic wr_remote;
  logic wr_xcvr1;
  logic wr_xcvr3;
  logic wr_xcvr4;

  // centre and carrier codes share the low five bits of both control registers
  function automatic logic [4:0] freq_field(input logic [7:0] ctl);
    freq_field = ctl[icfg_pkg::FREQ_MSB:icfg_pkg::FREQ_LSB];
  endfunction

  // bandwidth and pulse width codes share the top three bits
  function automatic logic [2:0] width_field(input logic [7:0] ctl);
    width_field = ctl[icfg_pkg::BW_MSB:icfg_pkg::BW_LSB];
  endfunction

  // word index from byte address; bank decides the map
  assign off = adr_i[4:2];
  assign in_bank7 = (bank_i == icfg_pkg::BANK_REMOTE);
  assign wr_stb = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

  // ack one cycle after request, dropped the next cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i && stb_i && !ack_o;
  end

  // shared link control / bank select reachable from every bank
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      link_control <= icfg_pkg::RST_LINK;
    else if (wr_stb && off == icfg_pkg::OFF_LINK_BANK)
      link_control <= dat_i[7:0];
  end

  // one write enable per register; bank 6 upper half has no storage and only acks
  assign wr_rx_demod = wr_stb && in_bank7 && (off == icfg_pkg::OFF_RX_DEMOD);
  assign wr_tx_mod = wr_stb && in_bank7 && (off == icfg_pkg::OFF_TX_MOD);
  assign wr_remote = wr_stb && in_bank7 && (off == icfg_pkg::OFF_REMOTE_CFG);
  assign wr_xcvr1 = wr_stb && in_bank7 && (off == icfg_pkg::OFF_XCVR_CFG1);
  assign wr_xcvr3 = wr_stb && in_bank7 && (off == icfg_pkg::OFF_XCVR_CFG3);
  assign wr_xcvr4 = wr_stb && in_bank7 && (off == icfg_pkg::OFF_XCVR_CFG4);

  // receiver demodulator control
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_demod_control <= icfg_pkg::RST_RX_DEMOD;
    else if (wr_rx_demod)
      rx_demod_control <= dat_i[7:0];
  end

  // transmitter modulator control
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_mod_control <= icfg_pkg::RST_TX_MOD;
    else if (wr_tx_mod)
      tx_mod_control <= dat_i[7:0];
  end

  // consumer remote configuration; reserved bit 3 always stores zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      remote_ctl_config <= icfg_pkg::RST_REMOTE_CFG;
    else if (wr_remote)
    begin
      remote_ctl_config <= dat_i[7:0];
      remote_ctl_config[icfg_pkg::RC_RSVD_BIT] <= 1'b0;
    end
  end

  // transceiver config 1: levels for the mode pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      transceiver_config_1 <= icfg_pkg::RST_XCVR;
    else if (wr_xcvr1)
      transceiver_config_1 <= dat_i[7:0];
  end

  // transceiver config 3: stored for the serial core, no local use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      transceiver_config_3 <= icfg_pkg::RST_XCVR;
    else if (wr_xcvr3)
      transceiver_config_3 <= dat_i[7:0];
  end

  // transceiver config 4: pin direction, auto config, uart mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      transceiver_config_4 <= icfg_pkg::RST_XCVR;
    else if (wr_xcvr4)
      transceiver_config_4 <= dat_i[7:0];
  end

  // read mux; reserved locations and other banks read zero, except link control at offset 3, which reads in every bank
  always_comb
  begin
    next_rd = icfg_pkg::RSVD_READ;
    if (off == icfg_pkg::OFF_LINK_BANK)
      next_rd = link_control;
    else if (in_bank7)
    begin
      case (off)
        icfg_pkg::OFF_RX_DEMOD: next_rd = rx_demod_control;
        icfg_pkg::OFF_TX_MOD: next_rd = tx_mod_control;
        icfg_pkg::OFF_REMOTE_CFG: next_rd = remote_ctl_config;
        icfg_pkg::OFF_XCVR_CFG1: next_rd = transceiver_config_1;
        icfg_pkg::OFF_XCVR_CFG3: next_rd = transceiver_config_3;
        icfg_pkg::OFF_XCVR_CFG4: next_rd = transceiver_config_4;
        default: next_rd = icfg_pkg::RSVD_READ;
      endcase
    end
  end

  // read data registered with the ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (cyc_i && stb_i && !ack_o)
      dat_o <= {24'h00_0000, next_rd};
  end

  // code validity; reserved codes are flagged, not blocked (software's duty)
  // flagging keeps a bad byte readable back, so software can see what it wrote
  icfg_code_check u_rx_code
  (
    .freq_code_i(freq_field(rx_demod_control)),
    .high_range_i(remote_ctl_config[icfg_pkg::RC_RX_HIGH_BIT]),
    .valid_o(rx_freq_ok)
  );
  icfg_code_check u_tx_code
  (
    .freq_code_i(freq_field(tx_mod_control)),
    .high_range_i(remote_ctl_config[icfg_pkg::RC_TX_HIGH_BIT]),
    .valid_o(tx_freq_ok)
  );
  // each range checker serves one half only; the idle half is tied off
  icfg_range_check u_rx_bw
  (
    .bw_code_i(width_field(rx_demod_control)),
    .pw_code_i(3'h0),
    .high_range_i(1'b0),
    .bw_valid_o(bw_ok),
    .pw_valid_o()
  );
  icfg_range_check u_tx_pw
  (
    .bw_code_i(3'h0),
    .pw_code_i(width_field(tx_mod_control)),
    .high_range_i(ask_mode_i | remote_ctl_config[icfg_pkg::RC_TX_HIGH_BIT]),
    .bw_valid_o(),
    .pw_valid_o(pw_ok)
  );

  // receive range and enable flags follow the remote config register directly
  // they land in the same cycle as the gated settings, so the receiver never mixes them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_high_range_o <= 1'b0;
      rx_demod_enable_o <= 1'b1;
    end
    else
    begin
      rx_demod_enable_o <= !remote_ctl_config[icfg_pkg::RC_DEMOD_DIS_BIT];
      rx_high_range_o <= remote_ctl_config[icfg_pkg::RC_RX_HIGH_BIT];
    end
  end

  // receiver settings; zeroed while demod disabled so stale codes never act
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_center_freq_o <= icfg_pkg::RST_RX_DEMOD[icfg_pkg::FREQ_MSB:icfg_pkg::FREQ_LSB];
      rx_bandwidth_o <= icfg_pkg::RST_RX_DEMOD[icfg_pkg::BW_MSB:icfg_pkg::BW_LSB];
      rx_cfg_valid_o <= 1'b1;
    end
    else if (remote_ctl_config[icfg_pkg::RC_DEMOD_DIS_BIT])
    begin
      rx_center_freq_o <= 5'h00;
      rx_bandwidth_o <= 3'h0;
      rx_cfg_valid_o <= 1'b0;
    end
    else
    begin
      rx_center_freq_o <= freq_field(rx_demod_control);
      rx_bandwidth_o <= width_field(rx_demod_control);
      // ask-ir ignores the centre code; only bandwidth matters there
      rx_cfg_valid_o <= bw_ok && (ask_mode_i || rx_freq_ok);
    end
  end

  // transmit range and ask-ir flags; ask-ir forces the 500 khz carrier
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_high_range_o <= 1'b0;
      tx_fixed_500k_o <= 1'b0;
    end
    else
    begin
      tx_high_range_o <= remote_ctl_config[icfg_pkg::RC_TX_HIGH_BIT];
      tx_fixed_500k_o <= ask_mode_i;
    end
  end

  // pulse width is taken in both transmit modes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_pulse_width_o <= icfg_pkg::RST_TX_MOD[icfg_pkg::BW_MSB:icfg_pkg::BW_LSB];
    else
      tx_pulse_width_o <= width_field(tx_mod_control);
  end

  // carrier code and validity; ask-ir has no carrier code to check
  // the stored code survives an ask-ir spell, so returning to remote mode needs no rewrite
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_carrier_freq_o <= icfg_pkg::RST_TX_MOD[icfg_pkg::FREQ_MSB:icfg_pkg::FREQ_LSB];
      tx_cfg_valid_o <= 1'b1;
    end
    else if (ask_mode_i)
    begin
      tx_carrier_freq_o <= 5'h00;
      tx_cfg_valid_o <= pw_ok;
    end
    else
    begin
      tx_carrier_freq_o <= freq_field(tx_mod_control);
      tx_cfg_valid_o <= pw_ok && tx_freq_ok;
    end
  end

  // transceiver mode selects; auto config in uart mode pulls them low only while the pins are set as outputs
  assign next_auto_low = transceiver_config_4[icfg_pkg::XC4_SEL_OUT_BIT] &&
    transceiver_config_4[icfg_pkg::XC4_AUTO_CFG_BIT] && transceiver_config_4[icfg_pkg::XC4_UART_BIT];
  // all three pins turn together; a split direction has no meaning to the transceiver
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_sel_o <= 3'h0;
      mode_sel_oe_o <= 3'h0;
    end
    else
    begin
      mode_sel_oe_o <= {3{transceiver_config_4[icfg_pkg::XC4_SEL_OUT_BIT]}};
      if (next_auto_low)
        mode_sel_o <= 3'h0;
      else
        mode_sel_o <= transceiver_config_1[icfg_pkg::XC1_MODE_MSB:icfg_pkg::XC1_MODE_LSB];
    end
  end

  // registered copy of the shared link control byte for the serial core
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      link_control_o <= icfg_pkg::RST_LINK;
    else
      link_control_o <= link_control;
  end
endmodule // icfg_bank

// File: tb/icfg_bank_chk.sv
// checker: bus timing and derived outputs of the ir config bank
`timescale 1ns/100ps
module icfg_bank_chk
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [2:0] bank_i,
  input wire logic ask_mode_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [4:0] rx_center_freq_o,
  input wire logic [2:0] rx_bandwidth_o,
  input wire logic rx_demod_enable_o,
  input wire logic rx_cfg_valid_o,
  input wire logic [4:0] tx_carrier_freq_o,
  input wire logic [2:0] tx_pulse_width_o,
  input wire logic tx_fixed_500k_o,
  input wire logic [2:0] mode_sel_o,
  input wire logic [2:0] mode_sel_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request as taken by the slave
  wire req = cyc_i && stb_i && !ack_o;
  wire [2:0] off = adr_i[4:2];
  ack_answer_a: assert property (req |=> ack_o) else $error("ack missing");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
  upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper read bits set");
  rsvd_read_a: assert property (req && !we_i && ((bank_i == 3'h7 && off == 3'h5) ||
    (bank_i == 3'h6 && off[2])) |=> dat_o == 32'h0) else $error("reserved read not zero");
  demod_off_a: assert property (!rx_demod_enable_o |-> rx_center_freq_o == 5'h0 &&
    rx_bandwidth_o == 3'h0 && !rx_cfg_valid_o) else $error("disabled demod leaks");
  ask_fixed_a: assert property (tx_fixed_500k_o == $past(ask_mode_i)) else $error("fixed carrier wrong");
  ask_nofreq_a: assert property ($past(ask_mode_i) |-> tx_carrier_freq_o == 5'h0) else $error("ask freq");
  oe_group_a: assert property (mode_sel_oe_o == 3'h0 || mode_sel_oe_o == 3'h7) else $error("oe split");
  uart_low_a: assert property (req && we_i && sel_i[0] && bank_i == 3'h7 && off == 3'h7 &&
    dat_i[2:0] == 3'h7 |-> ##[2:3] mode_sel_o == 3'h0) else $error("mode pins not low");
  reset_val_a: assert property ($past(rst_i) |-> rx_center_freq_o == 5'h09 &&
    rx_bandwidth_o == 3'h1 && tx_carrier_freq_o == 5'h09 && tx_pulse_width_o == 3'h3) else $error("reset value");
  // main scenarios reached
  cover property (req && we_i);
  cover property (!rx_demod_enable_o);
  cover property (mode_sel_oe_o == 3'h7 && mode_sel_o != 3'h0);
endmodule // icfg_bank_chk
bind icfg_bank icfg_bank_chk chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .bank_i(bank_i), .ask_mode_i(ask_mode_i), .dat_o(dat_o),
  .ack_o(ack_o), .rx_center_freq_o(rx_center_freq_o), .rx_bandwidth_o(rx_bandwidth_o),
  .rx_demod_enable_o(rx_demod_enable_o), .rx_cfg_valid_o(rx_cfg_valid_o), .tx_carrier_freq_o(tx_carrier_freq_o),
  .tx_pulse_width_o(tx_pulse_width_o), .tx_fixed_500k_o(tx_fixed_500k_o), .mode_sel_o(mode_sel_o),
  .mode_sel_oe_o(mode_sel_oe_o));

// File: tb/icfg_xcvr_model.sv
// model: external transceiver seeing the mode select pins
`timescale 1ns/100ps
module icfg_xcvr_model
(
  input wire logic [2:0] mode_sel_i,
  input wire logic [2:0] mode_oe_i,
  output logic [2:0] mode_pin_o
);
  // undriven pins sit on the transceiver's pull-downs, never on the last value
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      mode_pin_o[i] = mode_oe_i[i] ? mode_sel_i[i] : 1'b0;
  end
endmodule // icfg_xcvr_model

// File: tb/icfg_bank_tb.sv
// testbench: register access and derived outputs of the ir config bank
`timescale 1ns/100ps
module icfg_bank_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [4:0] adr_i = 5'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [2:0] bank_i = 3'h7;
  logic ask_mode_i = 1'b0;
  logic [31:0] dat_o;
  logic ack_o, rx_high_range_o, rx_demod_enable_o, rx_cfg_valid_o, tx_high_range_o, tx_fixed_500k_o, tx_cfg_valid_o;
  logic [4:0] rx_center_freq_o, tx_carrier_freq_o;
  logic [2:0] rx_bandwidth_o, tx_pulse_width_o, mode_sel_o, mode_sel_oe_o, pin;
  logic [7:0] link_control_o;
  logic [31:0] q;
  int mismatches = 0;
  int compares = 0;
  // 25 mhz core clock
  always #20 clk_i = ~clk_i;
  icfg_bank dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .bank_i(bank_i), .ask_mode_i(ask_mode_i),
    .rx_center_freq_o(rx_center_freq_o), .rx_bandwidth_o(rx_bandwidth_o), .rx_high_range_o(rx_high_range_o),
    .rx_demod_enable_o(rx_demod_enable_o), .rx_cfg_valid_o(rx_cfg_valid_o), .tx_carrier_freq_o(tx_carrier_freq_o),
    .tx_pulse_width_o(tx_pulse_width_o), .tx_high_range_o(tx_high_range_o), .tx_fixed_500k_o(tx_fixed_500k_o),
    .tx_cfg_valid_o(tx_cfg_valid_o), .mode_sel_o(mode_sel_o), .mode_sel_oe_o(mode_sel_oe_o),
    .link_control_o(link_control_o));
  icfg_xcvr_model xcvr (.mode_sel_i(mode_sel_o), .mode_oe_i(mode_sel_oe_o), .mode_pin_o(pin));
  task automatic end_of_test;
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; waits for ack, then one idle cycle
  task automatic wb(input logic w, input logic [2:0] bk, input logic [2:0] off, input logic [7:0] d);
    int n;
    n = 0;
    bank_i <= bk;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hf;
    adr_i <= {off, 2'b00};
    dat_i <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 20)
    begin
      mismatches++;
      end_of_test();
    end
  endtask
  // write, then let the derived outputs land
  task automatic wr(input logic [2:0] bk, input logic [2:0] off, input logic [7:0] d);
    wb(1'b1, bk, off, d);
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [2:0] bk, input logic [2:0] off, input logic [7:0] e);
    wb(1'b0, bk, off, 8'h0);
    chk("read", {24'h0, e}, q);
  endtask
  task automatic t_reset;
    chk("rx_freq", 5'h09, rx_center_freq_o);
    chk("rx_bw", 3'h1, rx_bandwidth_o);
    chk("rx_valid", 1'b1, rx_cfg_valid_o);
    chk("tx_pw", 3'h3, tx_pulse_width_o);
    rd(3'h7, 3'h0, 8'h29);
    rd(3'h7, 3'h1, 8'h69);
    for (int i = 2; i < 8; i++)
      rd(3'h7, i[2:0], 8'h00);
  endtask
  task automatic t_fields;
    wr(3'h7, 3'h0, 8'h4b);
    chk("rx_freq", 5'h0b, rx_center_freq_o);
    chk("rx_bw", 3'h2, rx_bandwidth_o);
    wr(3'h7, 3'h1, 8'h88);
    chk("tx_freq", 5'h08, tx_carrier_freq_o);
    chk("tx_pw", 3'h4, tx_pulse_width_o);
    rd(3'h7, 3'h0, 8'h4b);
    wr(3'h7, 3'h5, 8'hff);
    rd(3'h7, 3'h5, 8'h00);
    wr(3'h7, 3'h2, 8'hff);
    rd(3'h7, 3'h2, 8'hf7);
    chk("rx_en", 1'b0, rx_demod_enable_o);
    chk("rx_freq", 5'h0, rx_center_freq_o);
    wr(3'h7, 3'h2, 8'h04);
    chk("ranges", 2'h1, {rx_high_range_o, tx_high_range_o});
  endtask
  task automatic t_ranges;
    logic [4:0] cd [8] = '{5'h02, 5'h03, 5'h1e, 5'h1f, 5'h03, 5'h04, 5'h08, 5'h0b};
    logic [7:0] ok = 8'hd6;
    logic [2:0] pw [4] = '{3'h1, 3'h5, 3'h5, 3'h4};
    for (int i = 0; i < 8; i++)
    begin
      wr(3'h7, 3'h2, i < 4 ? 8'h00 : 8'h20);
      wr(3'h7, 3'h0, {3'h1, cd[i]});
      chk("rx_valid", ok[i], rx_cfg_valid_o);
    end
    wr(3'h7, 3'h0, 8'heb);
    chk("rx_valid", 1'b0, rx_cfg_valid_o);
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h7, 3'h2, i < 2 ? 8'h00 : 8'h04);
      wr(3'h7, 3'h1, {pw[i], 5'h0b});
      chk("tx_valid", i[0], tx_cfg_valid_o);
    end
  endtask
  task automatic t_bank6;
    for (int i = 4; i < 8; i++)
    begin
      wr(3'h6, i[2:0], 8'hff);
      rd(3'h6, i[2:0], 8'h00);
    end
    rd(3'h7, 3'h7, 8'h00);
    wr(3'h6, 3'h3, 8'h83);
    chk("link", 8'h83, link_control_o);
    rd(3'h7, 3'h3, 8'h83);
    wr(3'h7, 3'h3, 8'h00);
  endtask
  task automatic t_mode;
    wr(3'h7, 3'h4, 8'h05);
    wr(3'h7, 3'h6, 8'haa);
    rd(3'h7, 3'h6, 8'haa);
    wr(3'h7, 3'h7, 8'h03);
    chk("pins", 6'h3d, {mode_sel_oe_o, pin});
    wr(3'h7, 3'h7, 8'h07);
    chk("pins", 6'h38, {mode_sel_oe_o, pin});
    wr(3'h7, 3'h7, 8'h00);
    chk("pins", 6'h00, {mode_sel_oe_o, pin});
  endtask
  task automatic t_ask;
    ask_mode_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("fixed", 6'h20, {tx_fixed_500k_o, tx_carrier_freq_o});
    ask_mode_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("fixed", 1'b0, tx_fixed_500k_o);
  endtask
  // reset, then one task per scenario
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_fields();
    t_ranges();
    t_bank6();
    t_mode();
    t_ask();
    end_of_test();
  end
endmodule // icfg_bank_tb
